// *** bench/cpu_master.sv ***
// cpu core stand-in: one bus write or read at a time
// assumes outputs change only just after rising edges
`timescale 1ns/1ps
module cpu_master
(
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   int slow = 0;
   logic [3:0] strb = 4'h1;
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
      logic ta;
      logic tw;
      logic tb;
      int k;
      k = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (slow == 0);
      do
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         k++;
         if (ta)
         begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (tw)
         begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~{24'h000000, v};
         end
         if (k == slow)
         begin
            s_axi_bready <= 1'b1;
         end
      end while (!tb);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] r);
      logic ta;
      logic tr;
      int k;
      k = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (slow == 0);
      do
      begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid && s_axi_rready;
         v = s_axi_rdata[7:0];
         r = s_axi_rresp;
         @(posedge aclk);
         k++;
         if (ta)
         begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (k == slow)
         begin
            s_axi_rready <= 1'b1;
         end
      end while (!tr);
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : cpu_master

// *** bench/mdu_axi_monitor.sv ***
// bus assertions for the multiply/divide unit
// assumes binding to mul_div_unit, offsets from mdu_cfg.svh
`timescale 1ns/1ps
`include "mdu_cfg.svh"
module mul_div_axi_monitor
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [7:0] ar_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk)
   begin
      if (s_axi_arvalid && s_axi_arready)
      begin
         ar_q <= s_axi_araddr;
      end
   end
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_answer;
      ##[1:2] s_axi_bvalid;
   endsequence
   chk_write_answer: assert property (s_both_taken |-> s_answer)
      else $error("write not answered");
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   chk_bus_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   chk_rdata_hold: assert property
      (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   chk_arready_free: assert property (s_axi_arready != s_axi_rvalid)
      else $error("read address ready wrong");
   chk_rresp_code: assert property
      (s_axi_rvalid && ar_q[1:0] == 2'b00
         |-> s_axi_rresp == (ar_q <= `OFS_STATUS ? `AXI_OKAY : `AXI_SLVERR))
      else $error("read response code wrong");
   chk_status_spare: assert property
      (s_axi_rvalid && ar_q == `OFS_STATUS |-> s_axi_rdata[5:0] == 6'h00)
      else $error("status spare bits not zero");
   chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
endmodule : mul_div_axi_monitor
bind mul_div_unit mul_div_axi_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// *** bench/sequenced_mul_div_unit_test.sv ***
// self-checking bench of the multiply/divide unit against an integer model
// assumes cpu_master as bus partner and the bound bus monitor
`timescale 1ns/1ps
`include "mdu_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module sequenced_mul_div_unit_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h00000057;
   logic last_ovf = 1'b0;
   logic [31:0] num;
   logic [15:0] den;
   logic [7:0] d;
   logic [1:0] r;
   int ord [3][6] = '{'{0, 1, 2, 3, 4, 5}, '{0, 1, 4, 5, 0, 0}, '{0, 4, 1, 5, 0, 0}};
   int rds [3][6] = '{'{0, 1, 2, 3, 4, 5}, '{0, 1, 4, 5, 0, 0}, '{0, 1, 2, 3, 0, 0}};
   int nw [3] = '{6, 4, 4};
   int lat [3] = '{`DIV32_PERIODS, `DIV16_PERIODS, `MUL_PERIODS};
   mul_div_unit DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   cpu_master u_cpu (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   always #(`CLK_PERIOD_NS / 2) aclk = ~aclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   task automatic run(input int op, input logic [31:0] n, input logic [15:0] v, input bit bh);
      longint unsigned a;
      longint unsigned lo;
      longint unsigned hi;
      logic ovf;
      int k;
      a = (op == 0) ? n : n[15:0];
      ovf = (op == 2) ? (a * v > 64'hffff) : (v == 16'h0000);
      lo = (op == 2) ? a * v : (ovf ? a : a / v);
      hi = (op == 2 || ovf) ? 0 : a % v;
      for (int i = 0; i < nw[op]; i++)
      begin
         k = ord[op][i];
         u_cpu.wr(8'(4 * k), (k < 4) ? n[8 * k +: 8] : v[8 * (k - 4) +: 8], r);
         `CHK("write resp", `AXI_OKAY, r)
         if (i == 1)
         begin
            u_cpu.rd(`OFS_STATUS, d, r);
         end
      end
      if (bh && op == 1)
      begin
         u_cpu.wr(`OFS_BYTE4, 8'hff, r);
      end
      else if (bh)
      begin
         u_cpu.rd(`OFS_BYTE2, d, r);
      end
      repeat (lat[op] + 1) @(posedge aclk);
      u_cpu.rd(`OFS_STATUS, d, r);
      `CHK("status", {bh, ovf, 6'h00}, d)
      if (bh)
      begin
         u_cpu.rd(`OFS_STATUS, d, r);
         `CHK("status after clear", {1'b0, ovf, 6'h00}, d)
      end
      last_ovf = ovf;
      if (op == 2 || !ovf)
      begin
         for (int i = 0; i < nw[op]; i++)
         begin
            k = rds[op][i];
            u_cpu.rd(8'(4 * k), d, r);
            `CHK("result", 8'(((k < 4) ? lo : hi) >> (8 * (k % 4))), d)
            if (i == 0)
            begin
               u_cpu.rd(`OFS_STATUS, d, r);
            end
         end
      end
   endtask : run
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         conclude();
      end
   end
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      u_cpu.rd(`OFS_STATUS, d, r);
      `CHK("status reset", `STATUS_RESET, d)
      `CHK("status resp", `AXI_OKAY, r)
      u_cpu.wr(`OFS_STATUS, 8'hff, r);
      u_cpu.rd(`OFS_STATUS, d, r);
      `CHK("status read only", `STATUS_RESET, d)
      u_cpu.rd(8'h1c, d, r);
      `CHK("unmapped read", `AXI_SLVERR, r)
      u_cpu.wr(8'h20, 8'h00, r);
      `CHK("unmapped write", `AXI_SLVERR, r)
      $display("test registers done");
      for (int op = 0; op < 3; op++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            u_cpu.slow = i % 3;
            num = rnd();
            den = 16'(rnd());
            if (i == 1)
            begin
               num = num & 32'h000000ff;
               den = den & 16'h00ff;
            end
            if (i == 2 && op != 2)
            begin
               den = 16'h0000;
            end
            run(op, num, den, i == 3);
         end
      end
      $display("test operations done");
      u_cpu.wr(`OFS_BYTE0, 8'h11, r);
      u_cpu.wr(`OFS_BYTE1, 8'h22, r);
      u_cpu.wr(`OFS_BYTE2, 8'h33, r);
      u_cpu.wr(`OFS_BYTE5, 8'h44, r);
      u_cpu.strb = 4'h2;
      u_cpu.wr(`OFS_BYTE0, 8'h77, r);
      u_cpu.strb = 4'h1;
      u_cpu.rd(`OFS_BYTE0, d, r);
      `CHK("no launch data", 8'h11, d)
      u_cpu.rd(`OFS_STATUS, d, r);
      `CHK("no launch status", {1'b0, last_ovf, 6'h00}, d)
      u_cpu.wr(`OFS_BYTE0, 8'h55, r);
      u_cpu.wr(`OFS_BYTE4, 8'h66, r);
      run(1, rnd(), 16'(rnd()) | 16'h0001, 1'b0);
      $display("test order done");
      conclude();
   end
endmodule : sequenced_mul_div_unit_test

// *** design/calc_core.sv ***
// unsigned divide and multiply core with a fixed latency per operation
// assumes start is a one-cycle pulse while idle
`timescale 1ns/1ps
`include "mdu_cfg.svh"
module calc_core
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input mul_div_pkg::calc_req_t req,
   output logic busy,
   output logic done,
   output mul_div_pkg::calc_res_t res
);
   localparam int unsigned CNT_DIV32 = (`DIV32_PERIODS * `CLK_PERIOD_NS) / `CLK_PERIOD_NS;
   localparam int unsigned CNT_DIV16 = (`DIV16_PERIODS * `CLK_PERIOD_NS) / `CLK_PERIOD_NS;
   localparam int unsigned CNT_MUL = (`MUL_PERIODS * `CLK_PERIOD_NS) / `CLK_PERIOD_NS;
   logic [4:0] count;
   mul_div_pkg::calc_res_t held;

   function automatic mul_div_pkg::calc_res_t compute(input mul_div_pkg::calc_req_t r);
      logic [31:0] prod;
      begin
         compute = '0;
         prod = 32'(r.num[15:0]) * 32'(r.den);
         if (r.op == mul_div_pkg::op_mul)
         begin
            compute.lo = prod;
            compute.ovf = |prod[31:16];
         end
         else if (r.den == 16'h0000)
         begin
            compute.lo = r.num;
            compute.ovf = 1'b1;
         end
         else if (r.op == mul_div_pkg::op_div16)
         begin
            compute.lo = {16'h0000, r.num[15:0] / r.den};
            compute.hi = r.num[15:0] % r.den;
         end
         else
         begin
            compute.lo = r.num / 32'(r.den);
            compute.hi = 16'(r.num % 32'(r.den));
         end
      end
   endfunction : compute

   // busy spans the operation's period count
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count <= 5'd0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            busy <= 1'b1;
            case (req.op)
               mul_div_pkg::op_div32: count <= 5'(CNT_DIV32 - 1);
               mul_div_pkg::op_div16: count <= 5'(CNT_DIV16 - 1);
               default: count <= 5'(CNT_MUL - 1);
            endcase
         end
         else if (busy)
         begin
            // busy holds through the edge at which results land
            if (count == 5'd1)
            begin
               done <= 1'b1;
            end
            if (done)
            begin
               busy <= 1'b0;
            end
            count <= count - 5'd1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         held <= '0;
      else if (start && !busy)
         held <= compute(req);
   end

   assign res = held;
endmodule : calc_core

// *** design/mdu_cfg.svh ***
// constants of the multiply/divide unit: offsets, fields, reset values, latencies
// assumes inclusion by bare name from design files
`ifndef MUL_DIV_CFG_SVH
`define MUL_DIV_CFG_SVH
`define OFS_BYTE0 8'h00
`define OFS_BYTE1 8'h04
`define OFS_BYTE2 8'h08
`define OFS_BYTE3 8'h0c
`define OFS_BYTE4 8'h10
`define OFS_BYTE5 8'h14
`define OFS_STATUS 8'h18
`define STATUS_ERR_BIT 7
`define STATUS_OVF_BIT 6
`define STATUS_RESET 8'h00
`define CLK_PERIOD_NS 8
`define DIV32_PERIODS 17
`define DIV16_PERIODS 9
`define MUL_PERIODS 11
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// *** design/mdu_pkg.sv ***
// types of the multiply/divide unit
// assumes mdu_cfg.svh supplies the numbers
package mul_div_pkg;
   typedef enum logic [1:0] {op_none, op_div32, op_div16, op_mul} op_t;
   typedef struct packed {
      logic [31:0] num;
      logic [15:0] den;
      op_t op;
   } calc_req_t;
   typedef struct packed {
      logic [31:0] lo;
      logic [15:0] hi;
      logic ovf;
   } calc_res_t;
endpackage : mul_div_pkg

// *** design/mul_div_unit.sv ***
// register-mapped multiply/divide unit behind an AXI4-Lite slave
// assumes one clock aclk, synchronous active-low reset, cpu as bus master
//
// Overview of operation
// - calculation starts only on byte 5 write completing a known order.
// - other activity between operand writes does not disturb order tracking.
// - order 0,1,2,3,4,5 selects 32/16 division, ready after 17 clocks.
// - order 0,1,4,5 selects 16/16 division, ready after 9 clocks.
// - order 0,4,1,5 selects 16x16 multiply, ready after 11 clocks.
// - operand access while busy sets the error flag, status bit 7.
// - status read while idle clears a set error flag.
// - overflow bit 6 set for product above ffff or zero divisor.
// - each completed calculation overwrites the overflow flag.
// - 32/16 division leaves quotient in bytes 0-3, remainder in 4-5.
// - 16/16 division leaves quotient in bytes 0-1, remainder in 4-5.
// - multiply leaves 32-bit product in bytes 0-3, low byte first.
// - result reads survive unrelated activity between them.
// - entering sleep before completion may make a calculation fail.
// - status bits 5 to 0 read as zero.
// - all operands are unsigned.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "mdu_cfg.svh"
module mul_div_unit
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [7:0] operand_result_byte0;
   logic [7:0] operand_result_byte1;
   logic [7:0] operand_result_byte2;
   logic [7:0] operand_result_byte3;
   logic [7:0] operand_result_byte4;
   logic [7:0] operand_result_byte5;
   logic access_error_flag;
   logic overflow_flag;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic do_read;
   logic wr_operand;
   logic [2:0] wr_idx;
   logic rd_operand;
   logic rd_status;
   logic busy;
   logic done;
   mul_div_pkg::op_t launch_op;
   mul_div_pkg::calc_req_t req;
   mul_div_pkg::calc_res_t res;

   function automatic logic [3:0] decode(input logic [7:0] addr);
      begin
         case (addr)
            `OFS_BYTE0: decode = 4'h0;
            `OFS_BYTE1: decode = 4'h1;
            `OFS_BYTE2: decode = 4'h2;
            `OFS_BYTE3: decode = 4'h3;
            `OFS_BYTE4: decode = 4'h4;
            `OFS_BYTE5: decode = 4'h5;
            `OFS_STATUS: decode = 4'h6;
            default: decode = 4'hf;
         endcase
      end
   endfunction : decode

   // write channel: address and data captured in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (decode(aw_addr) == 4'hf) ? `AXI_SLVERR : `AXI_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // operand byte write needs lane 0; status is read-only
   assign wr_operand = do_write && w_strb[0] && decode(aw_addr) < 4'h6;
   assign wr_idx = decode(aw_addr) < 4'h6 ? 3'(decode(aw_addr)) : 3'd0;

   // read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign rd_operand = do_read && decode(s_axi_araddr) < 4'h6;
   assign rd_status = do_read && decode(s_axi_araddr) == 4'h6;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_OKAY;
      end
      else if (do_read)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `AXI_OKAY;
         // results read in place, no read-side effect on data
         case (decode(s_axi_araddr))
            4'h0: s_axi_rdata <= {24'h000000, operand_result_byte0};
            4'h1: s_axi_rdata <= {24'h000000, operand_result_byte1};
            4'h2: s_axi_rdata <= {24'h000000, operand_result_byte2};
            4'h3: s_axi_rdata <= {24'h000000, operand_result_byte3};
            4'h4: s_axi_rdata <= {24'h000000, operand_result_byte4};
            4'h5: s_axi_rdata <= {24'h000000, operand_result_byte5};
            4'h6: s_axi_rdata <= {24'h000000, access_error_flag, overflow_flag, 6'b000000};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `AXI_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   order_tracker u_tracker
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(wr_operand && !busy),
      .wr_idx(wr_idx),
      .launch_op(launch_op)
   );

   // operands as they stand including the launching byte
   always_comb
   begin
      req.num = {operand_result_byte3, operand_result_byte2,
                 operand_result_byte1, operand_result_byte0};
      req.den = {w_data[7:0], operand_result_byte4};
      req.op = launch_op;
      if (launch_op != mul_div_pkg::op_div32)
         req.num[31:16] = 16'h0000;
   end

   calc_core u_core
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(launch_op != mul_div_pkg::op_none),
      .req(req),
      .busy(busy),
      .done(done),
      .res(res)
   );

   // operand storage; writes while busy are dropped, results land on done
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         operand_result_byte0 <= 8'h00;
         operand_result_byte1 <= 8'h00;
         operand_result_byte2 <= 8'h00;
         operand_result_byte3 <= 8'h00;
         operand_result_byte4 <= 8'h00;
         operand_result_byte5 <= 8'h00;
      end
      else if (done)
      begin
         operand_result_byte0 <= res.lo[7:0];
         operand_result_byte1 <= res.lo[15:8];
         operand_result_byte2 <= res.lo[23:16];
         operand_result_byte3 <= res.lo[31:24];
         operand_result_byte4 <= res.hi[7:0];
         operand_result_byte5 <= res.hi[15:8];
      end
      else if (wr_operand && !busy)
      begin
         case (wr_idx)
            3'd0: operand_result_byte0 <= w_data[7:0];
            3'd1: operand_result_byte1 <= w_data[7:0];
            3'd2: operand_result_byte2 <= w_data[7:0];
            3'd3: operand_result_byte3 <= w_data[7:0];
            3'd4: operand_result_byte4 <= w_data[7:0];
            default: operand_result_byte5 <= w_data[7:0];
         endcase
      end
   end

   // error flag: set wins over the status-read clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         access_error_flag <= 1'(`STATUS_RESET >> `STATUS_ERR_BIT);
      else if (busy && (wr_operand || rd_operand))
         access_error_flag <= 1'b1;
      else if (rd_status && !busy && access_error_flag)
         access_error_flag <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         overflow_flag <= 1'b0;
      else if (done)
         overflow_flag <= res.ovf;
   end
endmodule : mul_div_unit

// *** design/order_tracker.sv ***
// tracks the order of operand byte writes and names the operation launched
// assumes one-cycle write strobes from the register slave
`timescale 1ns/1ps
module order_tracker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   output mul_div_pkg::op_t launch_op
);
   // bit n (0 to 4) set once byte n is written in a valid order so far; bit 5 stays clear
   logic [5:0] seen;
   logic mul_path;

   always_comb
   begin
      launch_op = mul_div_pkg::op_none;
      if (wr_en && wr_idx == 3'd5)
      begin
         if (seen == 6'b011111)
            launch_op = mul_div_pkg::op_div32;
         else if (seen == 6'b010011 && !mul_path)
            launch_op = mul_div_pkg::op_div16;
         else if (seen == 6'b010011 && mul_path)
            launch_op = mul_div_pkg::op_mul;
      end
   end

   // only operand writes move the tracker
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         seen <= 6'h00;
         mul_path <= 1'b0;
      end
      else if (wr_en)
      begin
         mul_path <= 1'b0;
         case (wr_idx)
            3'd0: seen <= 6'b000001;
            3'd1:
            begin
               seen <= (seen == 6'b000001 || seen == 6'b010001) ? (seen | 6'b000010) : 6'h00;
               mul_path <= (seen == 6'b010001);
            end
            3'd2: seen <= (seen == 6'b000011) ? 6'b000111 : 6'h00;
            3'd3: seen <= (seen == 6'b000111) ? 6'b001111 : 6'h00;
            3'd4:
            begin
               // 0,4 opens multiply; 0,1 / 0..3 then 4 opens division
               if (seen == 6'b000001 || seen == 6'b000011 || seen == 6'b001111)
                  seen <= seen | 6'b010000;
               else
                  seen <= 6'h00;
            end
            default: seen <= 6'h00;
         endcase
      end
   end
endmodule : order_tracker
